// ---- rtl/nba_pkg.sv ----
// Shared constants, encodings and carrier types of the nibble arithmetic and logic unit.
package nba_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths.
    localparam int NBA_DW = 4;
    localparam int NBA_AW = 7;
    localparam int NBA_BUS_AW = 2;
    localparam int NBA_BUS_DW = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // Data memory addresses at which the status word is mapped.
    localparam logic [NBA_AW-1:0] NBA_PSW_LO_ADDR = 7'h7E;
    localparam logic [NBA_AW-1:0] NBA_PSW_HI_ADDR = 7'h7F;

    // Register port offsets.
    localparam logic [NBA_BUS_AW-1:0] NBA_REG_STATUS = 2'h0;
    localparam logic [NBA_BUS_AW-1:0] NBA_REG_INDEX = 2'h1;
    localparam logic [NBA_BUS_AW-1:0] NBA_REG_RESULT = 2'h2;

    // Bit positions in the status register and in the result register.
    localparam int NBA_ST_DEC = 4;
    localparam int NBA_ST_CMP = 3;
    localparam int NBA_ST_CY = 2;
    localparam int NBA_ST_Z = 1;
    localparam int NBA_ST_IXE = 0;
    localparam int NBA_RES_BUSY = 5;
    localparam int NBA_RES_SKIP = 4;

    // Reset values.
    localparam logic [4:0] NBA_STATUS_RST = 5'h00;
    localparam logic [NBA_AW-1:0] NBA_INDEX_RST = 7'h00;
    localparam logic [NBA_BUS_DW-1:0] NBA_BUS_ZERO = 8'h00;

    // Decimal correction thresholds and offsets.
    localparam logic [5:0] NBA_DEC_TEN = 6'h0A;
    localparam logic [5:0] NBA_DEC_TWENTY = 6'h14;
    localparam logic [5:0] NBA_DEC_HIGH = 6'h1C;
    localparam logic [5:0] NBA_DEC_TWO = 6'h02;

    // Operand spaces.
    localparam logic NBA_SPACE_MEM = 1'b0;
    localparam logic NBA_SPACE_GREG = 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    // Instruction codes.
    typedef enum logic [3:0] {
        NBA_OP_ADD = 4'b0000,
        NBA_OP_SUM_WITH_CARRY_IN = 4'b0001,
        NBA_OP_SUB = 4'b0010,
        NBA_OP_DIFF_WITH_BORROW_IN = 4'b0011,
        NBA_OP_OR = 4'b0100,
        NBA_OP_AND = 4'b0101,
        NBA_OP_XOR = 4'b0110,
        NBA_OP_SKT = 4'b0111,
        NBA_OP_SKF = 4'b1000,
        NBA_OP_SKE = 4'b1001,
        NBA_OP_SKNE = 4'b1010,
        NBA_OP_SKGE = 4'b1011,
        NBA_OP_SKLT = 4'b1100,
        NBA_OP_ROTATE_RIGHT_THROUGH_CARRY = 4'b1101
    } nba_op_e;

    // Sequencing states.
    typedef enum logic [1:0] {
        NBA_FSM_IDLE = 2'b00,
        NBA_FSM_WAIT_A = 2'b01,
        NBA_FSM_WAIT_B = 2'b10,
        NBA_FSM_EXEC = 2'b11
    } nba_fsm_e;

    ////////////////////////////////////////////////////////////////////////////////
    // Status flip-flop.
    typedef struct packed {
        logic decimalMode;
        logic compareOnlyFlag;
        logic carryFlag;
        logic zeroFlag;
        logic indexEnableFlag;
    } nba_flags_s;

    // Operand read request; data return in the same cycle.
    typedef struct packed {
        logic en;
        logic space;
        logic [NBA_AW-1:0] addr;
    } nba_memrd_s;

    // Result write back.
    typedef struct packed {
        logic en;
        logic space;
        logic [NBA_AW-1:0] addr;
        logic [NBA_DW-1:0] data;
    } nba_memwr_s;

    // Whole state of the unit.
    typedef struct packed {
        nba_fsm_e fsm;
        nba_op_e op;
        logic aSpace;
        logic [NBA_AW-1:0] aAddr;
        logic needB;
        logic bImm;
        logic [NBA_AW-1:0] bAddr;
        logic [NBA_DW-1:0] tmpA;
        logic [NBA_DW-1:0] tmpB;
        nba_flags_s flags;
        logic [NBA_AW-1:0] index;
        nba_memrd_s rd;
        nba_memwr_s wr;
        logic done;
        logic skip;
        logic lastSkip;
        logic [NBA_DW-1:0] lastResult;
        logic [NBA_BUS_DW-1:0] busRdData;
    } nba_state_s;

endpackage

// ---- rtl/nba_alu.sv ----
// Nibble arithmetic and logic unit with binary and decimal add and subtract.
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps

module nba_alu
    import nba_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Instruction request from the sequencer.
    input wire logic reqValid,
    output logic reqReady,
    input wire nba_op_e reqOp,
    input wire logic reqImmForm,
    input wire logic [NBA_AW-1:0] reqRegAddr,
    input wire logic [NBA_AW-1:0] reqMemAddr,
    input wire logic [NBA_DW-1:0] reqImm,
    // Completion towards the sequencer.
    output logic doneValid,
    output logic doneSkip,
    // Operand reads from the general register and data memory.
    output nba_memrd_s memRd,
    input wire logic [NBA_DW-1:0] memRdData,
    // Result write back.
    output nba_memwr_s memWr,
    // Register port.
    input wire logic [NBA_BUS_AW-1:0] busAddr,
    input wire logic [NBA_BUS_DW-1:0] busWrData,
    input wire logic busWr,
    input wire logic busRd,
    output logic [NBA_BUS_DW-1:0] busRdData,
    // Status flags seen by the rest of the core.
    output nba_flags_s statusFlags
);

    ////////////////////////////////////////////////////////////////////////////////
    // Functions.

    // Corrects a 6-bit sum into carry and result nibble.
    function automatic logic [4:0] fixAdd(input logic [5:0] sum, input logic dec);
        logic [5:0] adj;
        adj = 6'h00;
        if (!dec) begin
            fixAdd = {sum[4], sum[3:0]};
        end else if (sum < NBA_DEC_TEN) begin
            fixAdd = {1'b0, sum[3:0]};
        end else if (sum < NBA_DEC_TWENTY) begin
            adj = sum - NBA_DEC_TEN;
            fixAdd = {1'b1, adj[3:0]};
        end else if (sum < NBA_DEC_HIGH) begin
            fixAdd = {1'b1, 2'b11, ~sum[1], sum[0]};
        end else begin
            adj = sum - NBA_DEC_TWO;
            fixAdd = {1'b1, adj[3:0]};
        end
    endfunction

    // Corrects a 6-bit two's complement difference into borrow and result nibble.
    function automatic logic [4:0] fixSub(input logic [5:0] diff, input logic dec);
        logic [5:0] adj;
        adj = diff + NBA_DEC_TEN;
        if (!dec) begin
            fixSub = {diff[5], diff[3:0]};
        end else if (!diff[5] && (diff < NBA_DEC_TEN)) begin
            fixSub = {1'b0, diff[3:0]};
        end else if (diff[5] && !adj[5]) begin
            fixSub = {1'b1, adj[3:0]};
        end else begin
            fixSub = {1'b1, 2'b11, adj[1:0]};
        end
    endfunction

    // True for the two addresses that hold the status word in data memory.
    function automatic logic isStatusAddr(input logic [NBA_AW-1:0] addr);
        isStatusAddr = (addr == NBA_PSW_LO_ADDR) || (addr == NBA_PSW_HI_ADDR);
    endfunction

    // Nibble of the status word at a given data memory address.
    function automatic logic [NBA_DW-1:0] statusNibble(input nba_flags_s f,
                                                       input logic [NBA_AW-1:0] addr);
        if (addr == NBA_PSW_LO_ADDR) begin
            statusNibble = {3'b000, f.decimalMode};
        end else begin
            statusNibble = {f.compareOnlyFlag, f.carryFlag, f.zeroFlag, f.indexEnableFlag};
        end
    endfunction

    // True for the four add and subtract codes.
    function automatic logic isArith(input nba_op_e op);
        isArith = (op == NBA_OP_ADD) || (op == NBA_OP_SUM_WITH_CARRY_IN) ||
                  (op == NBA_OP_SUB) || (op == NBA_OP_DIFF_WITH_BORROW_IN);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    nba_state_s st;
    nba_state_s next_st;

    logic [NBA_AW-1:0] idxMemAddr;
    logic [5:0] sumWide;
    logic [5:0] diffWide;
    logic [5:0] cmpWide;
    logic carryIn;
    logic [4:0] addOut;
    logic [4:0] subOut;
    logic [NBA_DW-1:0] operandA;

    ////////////////////////////////////////////////////////////////////////////////
    // Datapath.

    always_comb begin
        idxMemAddr = st.flags.indexEnableFlag ? (reqMemAddr | st.index) : reqMemAddr;
        carryIn = ((st.op == NBA_OP_SUM_WITH_CARRY_IN) || (st.op == NBA_OP_DIFF_WITH_BORROW_IN)) ?
                  st.flags.carryFlag : 1'b0;
        sumWide = {2'b00, st.tmpA} + {2'b00, st.tmpB} + {5'h00, carryIn};
        diffWide = {2'b00, st.tmpA} - {2'b00, st.tmpB} - {5'h00, carryIn};
        cmpWide = {2'b00, st.tmpA} - {2'b00, st.tmpB};
        addOut = fixAdd(sumWide, st.flags.decimalMode);
        subOut = fixSub(diffWide, st.flags.decimalMode);
        operandA = isStatusAddr(st.aAddr) && (st.aSpace == NBA_SPACE_MEM) ?
                   statusNibble(st.flags, st.aAddr) : memRdData;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        logic [NBA_DW-1:0] res;
        logic resCarry;
        logic store;
        res = 4'h0;
        resCarry = 1'b0;
        store = 1'b0;
        next_st = st;
        next_st.rd.en = 1'b0;
        next_st.wr.en = 1'b0;
        next_st.done = 1'b0;
        next_st.skip = 1'b0;

        unique case (st.fsm)
            NBA_FSM_IDLE: begin
                if (reqValid) begin
                    next_st.op = reqOp;
                    next_st.bImm = reqImmForm;
                    next_st.bAddr = idxMemAddr;
                    next_st.needB = (reqOp != NBA_OP_ROTATE_RIGHT_THROUGH_CARRY);
                    if (reqOp == NBA_OP_ROTATE_RIGHT_THROUGH_CARRY) begin
                        next_st.aSpace = NBA_SPACE_GREG;
                        next_st.aAddr = reqRegAddr;
                    end else if (reqImmForm) begin
                        next_st.aSpace = NBA_SPACE_MEM;
                        next_st.aAddr = idxMemAddr;
                    end else begin
                        next_st.aSpace = NBA_SPACE_GREG;
                        next_st.aAddr = reqRegAddr;
                    end
                    next_st.rd.en = 1'b1;
                    next_st.rd.space = next_st.aSpace;
                    next_st.rd.addr = next_st.aAddr;
                    next_st.fsm = NBA_FSM_WAIT_A;
                end
            end
            NBA_FSM_WAIT_A: begin
                next_st.tmpA = operandA;
                if (!st.needB) begin
                    next_st.fsm = NBA_FSM_EXEC;
                end else if (st.bImm) begin
                    next_st.tmpB = reqImm;
                    next_st.fsm = NBA_FSM_EXEC;
                end else begin
                    next_st.rd.en = 1'b1;
                    next_st.rd.space = NBA_SPACE_MEM;
                    next_st.rd.addr = st.bAddr;
                    next_st.fsm = NBA_FSM_WAIT_B;
                end
            end
            NBA_FSM_WAIT_B: begin
                next_st.tmpB = isStatusAddr(st.bAddr) ?
                               statusNibble(st.flags, st.bAddr) : memRdData;
                next_st.fsm = NBA_FSM_EXEC;
            end
            NBA_FSM_EXEC: begin
                next_st.done = 1'b1;
                next_st.fsm = NBA_FSM_IDLE;
                unique case (st.op)
                    NBA_OP_ADD, NBA_OP_SUM_WITH_CARRY_IN: begin
                        {resCarry, res} = addOut;
                    end
                    NBA_OP_SUB, NBA_OP_DIFF_WITH_BORROW_IN: begin
                        {resCarry, res} = subOut;
                    end
                    NBA_OP_OR: begin
                        res = st.tmpA | st.tmpB;
                    end
                    NBA_OP_AND: begin
                        res = st.tmpA & st.tmpB;
                    end
                    NBA_OP_XOR: begin
                        res = st.tmpA ^ st.tmpB;
                    end
                    NBA_OP_SKT: begin
                        next_st.skip = ((st.tmpA & st.tmpB) == st.tmpB);
                        next_st.flags.compareOnlyFlag = 1'b0;
                    end
                    NBA_OP_SKF: begin
                        next_st.skip = ((st.tmpA & st.tmpB) == 4'h0);
                        next_st.flags.compareOnlyFlag = 1'b0;
                    end
                    NBA_OP_SKE: begin
                        next_st.skip = (cmpWide == 6'h00);
                    end
                    NBA_OP_SKNE: begin
                        next_st.skip = (cmpWide != 6'h00);
                    end
                    NBA_OP_SKGE: begin
                        next_st.skip = !cmpWide[5];
                    end
                    NBA_OP_SKLT: begin
                        next_st.skip = cmpWide[5];
                    end
                    NBA_OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                        res = {st.flags.carryFlag, st.tmpA[3:1]};
                        next_st.flags.carryFlag = st.tmpA[0];
                    end
                    default: begin
                        res = st.tmpA;
                    end
                endcase

                if (isArith(st.op)) begin
                    next_st.flags.carryFlag = resCarry;
                    if (st.flags.compareOnlyFlag) begin
                        next_st.flags.zeroFlag = st.flags.zeroFlag && (res == 4'h0);
                    end else begin
                        next_st.flags.zeroFlag = (res == 4'h0);
                        store = 1'b1;
                    end
                end else begin
                    store = (st.op == NBA_OP_OR) || (st.op == NBA_OP_AND) ||
                            (st.op == NBA_OP_XOR) || (st.op == NBA_OP_ROTATE_RIGHT_THROUGH_CARRY);
                end

                if (store) begin
                    next_st.lastResult = res;
                    if (isStatusAddr(st.aAddr) && (st.aSpace == NBA_SPACE_MEM)) begin
                        if (st.aAddr == NBA_PSW_LO_ADDR) begin
                            next_st.flags.decimalMode = res[0];
                        end else begin
                            next_st.flags.compareOnlyFlag = res[3];
                            next_st.flags.carryFlag = res[2];
                            next_st.flags.zeroFlag = res[1];
                            next_st.flags.indexEnableFlag = res[0];
                        end
                    end else begin
                        next_st.wr.en = 1'b1;
                        next_st.wr.space = st.aSpace;
                        next_st.wr.addr = st.aAddr;
                        next_st.wr.data = res;
                    end
                end
                next_st.lastSkip = next_st.skip;
            end
            default: begin
                next_st.fsm = NBA_FSM_IDLE;
            end
        endcase

        // Software writes; an instruction finishing in the same cycle keeps its flags.
        if (busWr && (busAddr == NBA_REG_STATUS) && (st.fsm != NBA_FSM_EXEC)) begin
            next_st.flags = busWrData[4:0];
        end
        if (busWr && (busAddr == NBA_REG_INDEX)) begin
            next_st.index = busWrData[NBA_AW-1:0];
        end

        // Register reads, answered in the next cycle.
        next_st.busRdData = NBA_BUS_ZERO;
        if (busRd) begin
            unique case (busAddr)
                NBA_REG_STATUS: begin
                    next_st.busRdData = {3'b000, st.flags};
                end
                NBA_REG_INDEX: begin
                    next_st.busRdData = {1'b0, st.index};
                end
                NBA_REG_RESULT: begin
                    next_st.busRdData = {2'b00, (st.fsm != NBA_FSM_IDLE),
                                         st.lastSkip, st.lastResult};
                end
                default: begin
                    next_st.busRdData = NBA_BUS_ZERO;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.fsm <= NBA_FSM_IDLE;
            st.op <= NBA_OP_ADD;
            st.flags <= NBA_STATUS_RST;
            st.index <= NBA_INDEX_RST;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign reqReady = (st.fsm == NBA_FSM_IDLE);
    assign doneValid = st.done;
    assign doneSkip = st.skip;
    assign memRd = st.rd;
    assign memWr = st.wr;
    assign busRdData = st.busRdData;
    assign statusFlags = st.flags;

endmodule

// ---- testbench/nba_mem_model.sv ----
// Storage model of the sequencer side: general register file and data memory.
`timescale 1ns/1ps

module nba_mem_model
    import nba_pkg::*;
(
    // Clock.
    input wire logic core_clk,
    // Operand reads and result writes.
    input wire nba_memrd_s memRd,
    output logic [NBA_DW-1:0] memRdData,
    input wire nba_memwr_s memWr
);
    logic [NBA_DW-1:0] dmem [128];
    logic [NBA_DW-1:0] greg [128];
    logic [NBA_DW-1:0] lastRd = 4'h0;
    // Data stand in the cycle of the request; otherwise the last value is inverted.
    assign memRdData = memRd.en ? (memRd.space ? greg[memRd.addr] : dmem[memRd.addr]) : ~lastRd;
    always @(posedge core_clk) begin
        if (memRd.en) begin
            lastRd <= memRdData;
        end
        if (memWr.en && memWr.space) begin
            greg[memWr.addr] <= memWr.data;
        end else if (memWr.en) begin
            dmem[memWr.addr] <= memWr.data;
        end
    end
endmodule

// ---- testbench/nba_alu_checker.sv ----
// Port checks of the nibble arithmetic unit.
`timescale 1ns/1ps

module nba_alu_checker
    import nba_pkg::*;
(
    // Clock, reset and request.
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire nba_op_e reqOp,
    input wire logic reqImmForm,
    input wire logic [NBA_AW-1:0] reqRegAddr,
    // Completion, memory and flags.
    input wire logic doneValid,
    input wire logic doneSkip,
    input wire nba_memrd_s memRd,
    input wire logic [NBA_DW-1:0] memRdData,
    input wire nba_memwr_s memWr,
    input wire nba_flags_s statusFlags
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    logic rot;
    logic lgc;
    logic ari;
    assign rot = reqOp == NBA_OP_ROTATE_RIGHT_THROUGH_CARRY;
    assign lgc = reqOp inside {NBA_OP_OR, NBA_OP_AND, NBA_OP_XOR};
    assign ari = reqOp inside {NBA_OP_ADD, NBA_OP_SUM_WITH_CARRY_IN, NBA_OP_SUB, NBA_OP_DIFF_WITH_BORROW_IN};
    sequence s_take;
        reqValid && reqReady;
    endsequence
    a_short_done: assert property (s_take ##0 (reqImmForm || rot) |-> ##3 doneValid)
        else $error("short op late");
    a_long_done: assert property (s_take ##0 !(reqImmForm || rot) |-> ##4 doneValid)
        else $error("long op late");
    a_greg_read: assert property (s_take ##0 (rot || !reqImmForm) |=> memRd.en &&
        memRd.space == NBA_SPACE_GREG && memRd.addr == $past(reqRegAddr))
        else $error("first operand read wrong");
    a_rot_single: assert property (s_take ##0 rot |=> memRd.en ##1 !memRd.en
        ##1 !memRd.en)
        else $error("rotate read twice");
    a_rot_bits: assert property (s_take ##0 rot |-> ##3 memWr.en &&
        memWr.data == {$past(statusFlags.carryFlag, 3), $past(memRdData[3:1], 2)} &&
        statusFlags.carryFlag == $past(memRdData[0], 2))
        else $error("rotate result wrong");
    a_eval_quiet: assert property (s_take ##0 !(ari || lgc || rot)
        |-> ##3 doneValid && !memWr.en)
        else $error("evaluation stored");
    a_skip_done: assert property (doneSkip |-> doneValid)
        else $error("skip without done");
    a_bit_clear: assert property (s_take ##0 reqOp inside {NBA_OP_SKT, NBA_OP_SKF}
        |-> ##3 !statusFlags.compareOnlyFlag)
        else $error("compare-only not cleared");
    a_logic_flags: assert property (s_take ##0 lgc && reqImmForm
        |-> ##3 statusFlags == $past(statusFlags, 3))
        else $error("logic op changed flags");
    a_cmp_nostore: assert property (s_take ##0 ari && statusFlags.compareOnlyFlag
        |=> !memWr.en [*4])
        else $error("compare-only stored");
endmodule

bind nba_alu nba_alu_checker u_checker (
    .core_clk(core_clk), .rst_n(rst_n), .reqValid(reqValid), .reqReady(reqReady),
    .reqOp(reqOp), .reqImmForm(reqImmForm), .reqRegAddr(reqRegAddr), .doneValid(doneValid),
    .doneSkip(doneSkip), .memRd(memRd), .memRdData(memRdData), .memWr(memWr),
    .statusFlags(statusFlags)
);

// ---- testbench/nba_alu_tb.sv ----
// Self-checking bench of the nibble arithmetic unit.
`timescale 1ns/1ps

module nba_alu_tb
    import nba_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reqValid = 1'b0;
    nba_op_e reqOp = NBA_OP_ADD;
    logic reqImmForm = 1'b0;
    logic [NBA_AW-1:0] reqRegAddr = 7'h00;
    logic [NBA_AW-1:0] reqMemAddr = 7'h00;
    logic [NBA_DW-1:0] reqImm = 4'h0;
    logic [NBA_BUS_AW-1:0] busAddr = 2'h0;
    logic [NBA_BUS_DW-1:0] busWrData = 8'h00;
    logic busWr = 1'b0;
    logic busRd = 1'b0;
    logic reqReady;
    logic doneValid;
    logic doneSkip;
    nba_memrd_s memRd;
    logic [NBA_DW-1:0] memRdData;
    nba_memwr_s memWr;
    logic [NBA_BUS_DW-1:0] busRdData;
    nba_flags_s statusFlags;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic skipSeen;
    always #4 core_clk = ~core_clk;
    nba_alu u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .reqValid(reqValid), .reqReady(reqReady),
        .reqOp(reqOp), .reqImmForm(reqImmForm), .reqRegAddr(reqRegAddr),
        .reqMemAddr(reqMemAddr), .reqImm(reqImm), .doneValid(doneValid), .doneSkip(doneSkip),
        .memRd(memRd), .memRdData(memRdData), .memWr(memWr), .busAddr(busAddr),
        .busWrData(busWrData), .busWr(busWr), .busRd(busRd), .busRdData(busRdData),
        .statusFlags(statusFlags)
    );
    nba_mem_model u_mem (.core_clk(core_clk), .memRd(memRd), .memRdData(memRdData), .memWr(memWr));
    task automatic print_verdict();
        if (errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bw(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        busAddr <= a;
        busWrData <= d;
        busWr <= 1'b1;
        @(posedge core_clk);
        busWr <= 1'b0;
    endtask
    task automatic br(input logic [1:0] a, input logic [7:0] e);
        @(posedge core_clk);
        busAddr <= a;
        busRd <= 1'b1;
        @(posedge core_clk);
        busRd <= 1'b0;
        #1 chk(busRdData, e);
        @(posedge core_clk);
        #1 chk(busRdData, 8'h00);
    endtask
    task automatic run(input nba_op_e op, input logic f, input int ra, input int ma, input int iv);
        int n;
        n = 0;
        @(posedge core_clk);
        reqValid <= 1'b1;
        reqOp <= op;
        reqImmForm <= f;
        reqRegAddr <= 7'(ra);
        reqMemAddr <= 7'(ma);
        reqImm <= 4'(iv);
        @(posedge core_clk);
        reqValid <= 1'b0;
        do begin
            @(posedge core_clk);
            #1 n++;
        end while (doneValid !== 1'b1 && n < 8);
        skipSeen = doneSkip;
        chk(8'(n), (f || op == NBA_OP_ROTATE_RIGHT_THROUGH_CARRY) ? 8'h02 : 8'h03);
        @(posedge core_clk);
        #1;
    endtask
    task automatic arith();
        int k;
        int v;
        int x;
        int c;
        logic [3:0] e;
        for (k = 0; k < 128; k++) begin
            v = k[5] ? k % 32 - 16 : k % 32;
            c = k[5] ? int'(v < 0) : v % 2;
            x = k[5] ? (v < 0 ? 0 : v) : v / 2;
            e = 4'(v);
            if (k[6] && (v < 0 || v > 9)) begin
                if (v >= -10 && v < 0) e = 4'(v + 10);
                else if (!k[5] && v < 20) e = 4'(v - 10);
                else if (v >= 28) e = 4'(v - 18);
                else e = 4'hC | (4'(v + 2) & 4'h3);
            end
            bw(NBA_REG_STATUS, {3'h0, k[6], 1'b0, c[0], e != 4'h0, 1'b0});
            u_mem.dmem[16] = 4'(x);
            run(k[5] ? (c ? NBA_OP_DIFF_WITH_BORROW_IN : NBA_OP_SUB) : (c ? NBA_OP_SUM_WITH_CARRY_IN : NBA_OP_ADD), 1, 0, 16,
                k[5] ? (v < 0 ? -v - 1 : 0) : v - x - c);
            chk(u_mem.dmem[16], e);
            chk(statusFlags, {3'h0, k[6], 1'b0, v < 0 || v > 15 || (k[6] && v > 9),
                e == 4'h0, 1'b0});
        end
    endtask
    task automatic cmp_only();
        u_mem.greg[3] = 4'h5;
        u_mem.dmem[20] = 4'hB;
        bw(NBA_REG_STATUS, 8'h0A);
        run(NBA_OP_ADD, 0, 3, 20, 0);
        chk(u_mem.greg[3], 8'h05);
        chk(statusFlags, 8'h0E);
        run(NBA_OP_SUB, 0, 3, 20, 0);
        chk(statusFlags, 8'h0C);
        bw(NBA_REG_STATUS, 8'h00);
        run(NBA_OP_SUB, 0, 3, 20, 0);
        chk(u_mem.greg[3], 8'h0A);
        chk(statusFlags, 8'h04);
    endtask
    task automatic logic_ops();
        int i;
        logic [7:0] e;
        for (i = 0; i < 6; i++) begin
            u_mem.greg[5] = 4'hC;
            u_mem.dmem[24] = i[0] ? 4'hC : 4'hA;
            bw(NBA_REG_STATUS, 8'h1E);
            run(nba_op_e'(4 + i / 2), i[0], 5, 24, 10);
            e = i < 2 ? 8'h0E : (i < 4 ? 8'h08 : 8'h06);
            chk(i[0] ? u_mem.dmem[24] : u_mem.greg[5], e);
            chk(statusFlags, 8'h1E);
        end
    endtask
    task automatic evals();
        logic [15:0] t [14] = '{16'h7BB1, 16'h7BD0, 16'h8961, 16'h89E0, 16'h9AA1, 16'h9A80,
            16'hAA81, 16'hAAA0, 16'hB871, 16'hB881, 16'hB890, 16'hC891, 16'hC880, 16'hC870};
        int i;
        for (i = 0; i < 14; i++) begin
            u_mem.dmem[28] = t[i][11:8];
            bw(NBA_REG_STATUS, 8'h08);
            run(nba_op_e'(t[i][15:12]), 1, 0, 28, t[i][7:4]);
            chk(skipSeen, t[i][0]);
            chk(u_mem.dmem[28], t[i][11:8]);
            chk(statusFlags, t[i][15:12] < 4'h9 ? 8'h00 : 8'h08);
            br(NBA_REG_RESULT, {3'h0, t[i][0], 4'h6});
        end
    endtask
    task automatic others();
        u_mem.greg[6] = 4'hB;
        bw(NBA_REG_STATUS, 8'h02);
        run(NBA_OP_ROTATE_RIGHT_THROUGH_CARRY, 1, 6, 0, 0);
        chk(u_mem.greg[6], 8'h05);
        chk(statusFlags, 8'h06);
        run(NBA_OP_ROTATE_RIGHT_THROUGH_CARRY, 0, 6, 0, 0);
        chk(u_mem.greg[6], 8'h0A);
        bw(NBA_REG_INDEX, 8'h10);
        br(NBA_REG_INDEX, 8'h10);
        bw(NBA_REG_STATUS, 8'h01);
        u_mem.dmem[5] = 4'h9;
        u_mem.dmem[21] = 4'h3;
        run(NBA_OP_ADD, 1, 0, 5, 1);
        chk(u_mem.dmem[21], 8'h04);
        chk(u_mem.dmem[5], 8'h09);
        bw(NBA_REG_STATUS, 8'h00);
        run(NBA_OP_ADD, 1, 0, NBA_PSW_HI_ADDR, 6);
        chk(statusFlags, 8'h06);
        br(NBA_REG_RESULT, 8'h06);
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        br(NBA_REG_STATUS, 8'h00);
        br(2'h3, 8'h00);
        arith();
        cmp_only();
        logic_ops();
        evals();
        others();
        print_verdict();
    end
endmodule
